// >>> opc_params.svh
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH
`define OPC_OUTS        8
`define OPC_PLLS        2
`define OPC_SRCS        6
`define OPC_N_W         18
`define OPC_F_W         28
`define OPC_CNT_W       20
`define OPC_CW          5
`define OPC_N_MIN       18'h00004
`define OPC_N_INT_MIN   18'h00003
`define OPC_BYPASS      3'h1
`define OPC_SPACE_LAST  2'h3
`define OPC_FINE_SHIFT  4
`define OPC_CLK_NS      5
`define OPC_SETTLE_NS   350
`define OPC_SETTLE_CYC  (`OPC_SETTLE_NS / `OPC_CLK_NS)
`define OPC_SLEW0       16'h0010
`define OPC_SLEW1       16'h0040
`define OPC_SLEW2       16'h0100
`define OPC_SLEW3       16'h0400
`define OPC_SEL_PLL0    3'h0
`define OPC_SEL_PLL1    3'h1
`define OPC_SEL_FRAC2   3'h2
`define OPC_SEL_FRAC3   3'h3
`endif

// >>> opc_pkg.sv
package opc_pkg;
  // per-PLL output synchronisation sequence
  typedef enum logic [1:0] {SYN_RUN, SYN_LOST, SYN_SETTLE} opc_sync_e;
endpackage : opc_pkg

// >>> opc_div.sv
`timescale 1ns/100ps
`include "opc_params.svh"
module opc_div
  import opc_pkg::*;
#(
  parameter int CNT_W = `OPC_CNT_W
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  src_tick,
  input  wire logic                  power_down,
  input  wire logic                  resync,
  input  wire logic                  lock_lost,
  input  wire logic                  frac_mode,
  input  wire logic                  int_only,
  input  wire logic [`OPC_N_W-1:0]   n_int,
  input  wire logic [`OPC_F_W-1:0]   frac,
  input  wire logic [2:0]            stage1,
  input  wire logic [16:0]           stage2,
  input  wire logic [3:0]            fine_off,
  input  wire logic                  coarse_trig,
  input  wire logic [`OPC_CW-1:0]    coarse_amt,
  input  wire logic                  slope_step,
  output logic                       clk_out,
  output logic                       rise,
  output logic                       busy,
  output logic                       ratio_ok
);
  if (CNT_W < `OPC_CNT_W) begin : g_bad_width
    $error("counter narrower than the largest divide ratio");
  end

  logic [CNT_W-1:0]      cnt, per_base, per_len, half, last, fine_start;
  logic [CNT_W+3:0]      fine_prod;
  logic [19:0]           int_prod;
  logic [`OPC_F_W-1:0]   acc, frac_eff;
  logic [`OPC_F_W+1:0]   acc_sum;
  logic [`OPC_CW-1:0]    remaining;
  logic [1:0]            sp;
  logic                  ext, slope_pend, bypass, at_last;
  logic                  need_coarse, need, wrap, took, took_coarse;

  // ratio: integer stages or twice N.F with fraction carry
  assign bypass   = !frac_mode && (stage1 == `OPC_BYPASS);
  assign int_prod = {17'h00000, stage1} * {3'h0, stage2};
  assign frac_eff = (frac_mode && !int_only) ? frac : '0;
  assign acc_sum  = {2'h0, acc} + {1'h0, frac_eff, 1'h0};
  assign per_base = frac_mode ? CNT_W'({n_int, 1'h0}) : CNT_W'(int_prod);
  assign per_len  = per_base + (frac_mode ? CNT_W'(acc_sum[29:28]) : '0);
  assign half     = per_len >> 1;
  assign last     = per_len - CNT_W'(1);
  assign at_last  = cnt >= last;
  // integer-only fractional mode also allows N of three
  assign ratio_ok = !frac_mode || (n_int >= `OPC_N_MIN) ||
                    ((n_int == `OPC_N_INT_MIN) && (int_only || frac == '0));

  // start point after resync: fine jump, or one step early on bypass
  assign fine_prod  = (CNT_W+4)'(per_base) * (CNT_W+4)'(fine_off);
  assign fine_start = frac_mode ? fine_prod[CNT_W+3:`OPC_FINE_SHIFT]
                    : (bypass ? CNT_W'(1) : '0);

  // one extra source step when coarse or slope step is due
  assign need_coarse = (remaining != '0) && (sp == 2'h0);
  assign need        = need_coarse || slope_pend;
  assign wrap        = src_tick && at_last && !(need && !ext);
  assign took        = wrap && ext;
  assign took_coarse = took && need_coarse;
  assign busy        = remaining != '0;

  // period counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      ext <= 1'b0;
    end else if (power_down) begin
      cnt <= '0;
      ext <= 1'b0;
    end else if (resync) begin
      cnt <= fine_start;
      ext <= 1'b0;
    end else if (src_tick) begin
      if (wrap) begin
        cnt <= '0;
        ext <= 1'b0;
      end else if (at_last) begin
        ext <= 1'b1;
      end else begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // fraction accumulator, restarted on resync without phase promise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
    end else if (power_down || resync) begin
      acc <= '0;
    end else if (wrap) begin
      acc <= acc_sum[`OPC_F_W-1:0];
    end
  end

  // coarse request: remaining steps and four-period spacing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remaining <= '0;
      sp        <= 2'h0;
    end else if (power_down || resync || lock_lost) begin
      remaining <= '0;
      sp        <= 2'h0;
    end else if (coarse_trig && !bypass && !busy) begin
      remaining <= coarse_amt;
      sp        <= 2'h0;
    end else if (wrap) begin
      if (took_coarse) begin
        remaining <= remaining - `OPC_CW'(1);
        sp        <= 2'h1;
      end else if (sp != 2'h0) begin
        sp <= sp + 2'h1;
      end
    end
  end

  // slope step pending; a new step wins over consumption
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slope_pend <= 1'b0;
    end else if (power_down || resync) begin
      slope_pend <= 1'b0;
    end else if (slope_step) begin
      slope_pend <= 1'b1;
    end else if (took && !need_coarse) begin
      slope_pend <= 1'b0;
    end
  end

  // registered output level and rising-edge pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_out <= 1'b0;
      rise    <= 1'b0;
    end else begin
      clk_out <= !power_down && (cnt < half);
      rise    <= wrap && !power_down;
    end
  end

  sequence s_trig_ok;
    coarse_trig && !bypass && !busy && !power_down && !resync && !lock_lost;
  endsequence

  chk_coarse_load: assert property (@(posedge clk) disable iff (!resetn)
    s_trig_ok |=> remaining == $past(coarse_amt))
    else $error("coarse request not loaded");
  chk_bypass_coarse: assert property (@(posedge clk) disable iff (!resetn)
    coarse_trig && bypass && !busy |=> !busy)
    else $error("coarse step accepted in bypass");
  chk_step_space: assert property (@(posedge clk) disable iff (!resetn)
    took_coarse && !resync && !lock_lost && !power_down |=> sp == 2'h1)
    else $error("coarse spacing not restarted");
  chk_resync_clear: assert property (@(posedge clk) disable iff (!resetn)
    resync |=> !busy)
    else $error("resync left coarse delay pending");
  chk_fine_jump: assert property (@(posedge clk) disable iff (!resetn)
    resync && frac_mode && !power_down |=> cnt == $past(fine_start))
    else $error("fine offset not loaded on resync");
  chk_power_off: assert property (@(posedge clk) disable iff (!resetn)
    power_down [*2] |-> !clk_out && cnt == '0)
    else $error("powered-off divider still running");
endmodule : opc_div

// >>> opc_top.sv
`timescale 1ns/100ps
`include "opc_params.svh"
module opc_top
  import opc_pkg::*;
#(
  parameter int CNT_W = `OPC_CNT_W
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [1:0]               pll_clk,
  input  wire logic [2:0]               ref_clk,
  input  wire logic                     xtal_clk,
  input  wire logic [1:0]               loss_of_lock_flag,
  input  wire logic [1:0]               hold_flag,
  input  wire logic [3:0]               los_flag,
  input  wire logic [1:0]               switch_event,
  input  wire logic [9:0]               switch_phase_err,
  input  wire logic [1:0]               hitless_switch_select,
  input  wire logic [3:0]               phase_slope_rate,
  input  wire logic [1:0]               output_resync_toggle,
  input  wire logic                     pll1_shutdown,
  input  wire logic [23:0]              divider_source_select,
  input  wire logic [35:0]              frac_n,
  input  wire logic [55:0]              frac_f,
  input  wire logic [1:0]               frac_int_only,
  input  wire logic [7:0]               fine_delay,
  input  wire logic [23:0]              int_stage1,
  input  wire logic [135:0]             int_stage2,
  input  wire logic [39:0]              coarse_amount,
  input  wire logic [7:0]               coarse_trigger,
  input  wire logic [7:0]               out_invert,
  input  wire logic [7:0]               out_enable,
  input  wire logic [7:0]               out_power_down,
  input  wire logic [7:0]               cmos_mode,
  input  wire logic [7:0]               cmos_in_phase,
  input  wire logic                     config_loaded,
  input  wire logic [7:0]               gpio_drive_out,
  input  wire logic [7:0]               gpio_fixed_func,
  input  wire logic [7:0]               gpio_oe_func,
  input  wire logic [7:0]               gpio_value,
  input  wire logic [7:0]               gpio_i,
  output logic [7:0]                    gpio_o,
  output logic [7:0]                    gpio_oe,
  output logic [7:0]                    gpio_input_state,
  output logic [7:0]                    q,
  output logic [7:0]                    nq,
  output logic [7:0]                    q_oe,
  output logic [7:0]                    coarse_busy,
  output logic [1:0]                    ratio_ok,
  output logic [1:0]                    pll_settling
);
  localparam logic [7:0] SETTLE_CYC = 8'(`OPC_SETTLE_CYC);

  logic [`OPC_SRCS-1:0]  src_m, src_s, src_d, src_edge;
  logic [7:0]            gpio_m, gpio_s, status_map, oe_eff;
  logic [7:0]            srcs, rise, div_clk, trig_q, div_ok;
  logic [1:0]            lol_eff, pll_resync, slope_step, tog_q;

  // source clocks: two-flop synchronisers, edges seen after stage two
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_m <= '0;
      src_s <= '0;
      src_d <= '0;
    end else begin
      src_m <= {xtal_clk, ref_clk, pll_clk};
      src_s <= src_m;
      src_d <= src_s;
    end
  end
  assign src_edge = src_s & ~src_d;

  // source vector in select-code order, second PLL gated when shut
  assign srcs = {src_edge[5:2], rise[3], rise[2],
                 src_edge[1] & ~pll1_shutdown, src_edge[0]};
  assign lol_eff = {loss_of_lock_flag[1] | pll1_shutdown,
                    loss_of_lock_flag[0]};

  // edge memories for software toggle bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_q  <= '0;
      trig_q <= '0;
    end else begin
      tog_q  <= output_resync_toggle;
      trig_q <= coarse_trigger;
    end
  end

  // per-PLL resync sequencing and slope-limited phase walk
  for (genvar p = 0; p < `OPC_PLLS; p++) begin : g_pll
    opc_sync_e  state;
    logic [7:0] settle;
    logic [4:0] slope_left;
    logic [15:0] slope_tmr, slope_int;
    logic       tog_edge;

    assign tog_edge = output_resync_toggle[p] ^ tog_q[p];
    assign pll_resync[p] = !lol_eff[p] &&
                           ((state == SYN_LOST) || tog_edge);
    assign pll_settling[p] = state != SYN_RUN;

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        state  <= SYN_LOST;
        settle <= '0;
      end else begin
        case (state)
          SYN_RUN: begin
            if (lol_eff[p]) begin
              state <= SYN_LOST;
            end else if (tog_edge) begin
              state  <= SYN_SETTLE;
              settle <= SETTLE_CYC;
            end
          end
          SYN_LOST: begin
            if (!lol_eff[p]) begin
              state  <= SYN_SETTLE;
              settle <= SETTLE_CYC;
            end
          end
          SYN_SETTLE: begin
            if (lol_eff[p]) begin
              state <= SYN_LOST;
            end else if (tog_edge) begin
              settle <= SETTLE_CYC;
            end else if (settle == 8'h01) begin
              state <= SYN_RUN;
            end else begin
              settle <= settle - 8'h01;
            end
          end
          default: state <= SYN_LOST;
        endcase
      end
    end

    // slew interval from the two-bit rate field
    always_comb begin
      case (phase_slope_rate[2*p +: 2])
        2'h0:    slope_int = `OPC_SLEW0;
        2'h1:    slope_int = `OPC_SLEW1;
        2'h2:    slope_int = `OPC_SLEW2;
        default: slope_int = `OPC_SLEW3;
      endcase
    end

    // hitless keeps phase; slope mode walks the error out stepwise
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        slope_left <= '0;
        slope_tmr  <= '0;
      end else if (switch_event[p] && !hitless_switch_select[p]) begin
        slope_left <= switch_phase_err[5*p +: 5];
        slope_tmr  <= slope_int;
      end else if (hitless_switch_select[p]) begin
        slope_left <= '0;
      end else if (slope_left != '0) begin
        if (slope_tmr == '0) begin
          slope_left <= slope_left - 5'h01;
          slope_tmr  <= slope_int;
        end else begin
          slope_tmr <= slope_tmr - 16'h0001;
        end
      end
    end
    assign slope_step[p] = (slope_left != '0) && (slope_tmr == '0) &&
                           !hitless_switch_select[p] && !switch_event[p];

    sequence s_relock;
      state == SYN_LOST && !lol_eff[p];
    endsequence
    chk_relock_resync: assert property (@(posedge clk) disable iff (!resetn)
      s_relock |-> pll_resync[p] ##1 state == SYN_SETTLE)
      else $error("relock did not start resync");
    chk_settle_len: assert property (@(posedge clk) disable iff (!resetn)
      s_relock ##1 (!lol_eff[p] && !tog_edge) [*8] |-> pll_settling[p])
      else $error("settling window ended early");
    chk_hitless_hold: assert property (@(posedge clk) disable iff (!resetn)
      hitless_switch_select[p] |=> !slope_step[p])
      else $error("phase moved in hitless mode");
  end

  // GPIO: enable input until configured, then fixed or driven
  assign status_map = {los_flag[3], los_flag[2], los_flag[1], hold_flag[1],
                       loss_of_lock_flag[1], los_flag[0], hold_flag[0],
                       loss_of_lock_flag[0]};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpio_m  <= '0;
      gpio_s  <= '0;
      gpio_o  <= '0;
      gpio_oe <= '0;
    end else begin
      gpio_m  <= gpio_i;
      gpio_s  <= gpio_m;
      gpio_oe <= {8{config_loaded}} & gpio_drive_out;
      gpio_o  <= (gpio_fixed_func & status_map) |
                 (~gpio_fixed_func & gpio_value);
    end
  end
  assign gpio_input_state = gpio_s;
  assign oe_eff = config_loaded ?
                  (~(gpio_oe_func & ~gpio_drive_out) | gpio_s) : gpio_s;

  // output dividers and pin stages
  for (genvar i = 0; i < `OPC_OUTS; i++) begin : g_out
    localparam bit IS_FRAC = (i == 2) || (i == 3);
    localparam int K = (i == 3) ? 1 : 0;
    logic [2:0] sel, sel_eff;
    logic       pidx, has_pll, resync_i, lost_i, step_i, trig_i;

    assign sel     = divider_source_select[3*i +: 3];
    assign sel_eff = (i < 4) ? {2'h0, sel[0]} : sel;
    // owning PLL: direct, or through a fractional source
    always_comb begin
      pidx    = 1'b0;
      has_pll = 1'b1;
      case (sel_eff)
        `OPC_SEL_PLL0:  pidx = 1'b0;
        `OPC_SEL_PLL1:  pidx = 1'b1;
        `OPC_SEL_FRAC2: pidx = divider_source_select[6];
        `OPC_SEL_FRAC3: pidx = divider_source_select[9];
        default:        has_pll = 1'b0;
      endcase
    end
    assign resync_i = has_pll && pll_resync[pidx];
    assign lost_i   = has_pll && lol_eff[pidx];
    assign step_i   = has_pll && slope_step[pidx];
    assign trig_i   = coarse_trigger[i] ^ trig_q[i];

    opc_div #(.CNT_W(CNT_W)) u_div (
      .clk         (clk),
      .resetn      (resetn),
      .src_tick    (srcs[sel_eff]),
      .power_down  (out_power_down[i]),
      .resync      (resync_i),
      .lock_lost   (lost_i),
      .frac_mode   (IS_FRAC),
      .int_only    (frac_int_only[K]),
      .n_int       (IS_FRAC ? frac_n[18*K +: 18] : '0),
      .frac        (IS_FRAC ? frac_f[28*K +: 28] : '0),
      .stage1      (int_stage1[3*i +: 3]),
      .stage2      (int_stage2[17*i +: 17]),
      .fine_off    (IS_FRAC ? fine_delay[4*K +: 4] : 4'h0),
      .coarse_trig (trig_i),
      .coarse_amt  (coarse_amount[5*i +: 5]),
      .slope_step  (step_i),
      .clk_out     (div_clk[i]),
      .rise        (rise[i]),
      .busy        (coarse_busy[i]),
      .ratio_ok    (div_ok[i])
    );

    // pin stage: inversion, single-ended pairing, gated drive
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        q[i]    <= 1'b0;
        nq[i]   <= 1'b1;
        q_oe[i] <= 1'b0;
      end else begin
        q[i]    <= div_clk[i] ^ out_invert[i];
        nq[i]   <= (cmos_mode[i] && cmos_in_phase[i]) ?
                   (div_clk[i] ^ out_invert[i]) :
                   !(div_clk[i] ^ out_invert[i]);
        q_oe[i] <= out_enable[i] && oe_eff[i] && !out_power_down[i];
      end
    end

    chk_drive_gate: assert property (@(posedge clk) disable iff (!resetn)
      q_oe[i] |-> $past(out_enable[i]) && $past(oe_eff[i]))
      else $error("output driven without both enables");
  end

  // fractional ratio legality per fractional divider
  assign ratio_ok = {div_ok[3], div_ok[2]};

  chk_gpio_default: assert property (@(posedge clk) disable iff (!resetn)
    !config_loaded |=> gpio_oe == 8'h00)
    else $error("gpio driven before configuration");
endmodule : opc_top

// >>> opc_rx_model.sv
`timescale 1ns/100ps
module opc_rx_model
  import opc_pkg::*;
#(
  parameter int NOM = 16
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        line,
  input  wire logic        oe,
  output logic      [15:0] period,
  output logic      [7:0]  long_cnt,
  output logic      [7:0]  gap
);
  logic        prev;
  logic [15:0] cnt;
  logic [7:0]  since;

  // receiver: period between rising edges, counts stretched periods
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev     <= 1'h0;
      cnt      <= 16'h0;
      since    <= 8'h0;
      period   <= 16'h0;
      long_cnt <= 8'h0;
      gap      <= 8'h0;
    end else begin
      prev <= line;
      cnt  <= cnt + 16'h1;
      if (oe && line && !prev) begin
        period <= cnt + 16'h1;
        cnt    <= 16'h0;
        if (cnt + 16'h1 > NOM[15:0]) begin
          long_cnt <= long_cnt + 8'h1;
          gap      <= since;
          since    <= 8'h1;
        end else begin
          since <= since + 8'h1;
        end
      end
    end
  end
endmodule : opc_rx_model

// >>> tb_opc_top.sv
`timescale 1ns/100ps
module tb_opc_top
  import opc_pkg::*;
;
  logic         clk, resetn, xtal_clk, pll1_shutdown, config_loaded;
  logic [1:0]   pll_clk, loss_of_lock_flag, hold_flag, switch_event;
  logic [1:0]   hitless_switch_select, output_resync_toggle, frac_int_only;
  logic [1:0]   ratio_ok, pll_settling;
  logic [2:0]   ref_clk;
  logic [3:0]   los_flag, phase_slope_rate;
  logic [9:0]   switch_phase_err;
  logic [23:0]  divider_source_select, int_stage1;
  logic [35:0]  frac_n;
  logic [55:0]  frac_f;
  logic [135:0] int_stage2;
  logic [39:0]  coarse_amount;
  logic [7:0]   fine_delay, coarse_trigger, out_invert, out_enable;
  logic [7:0]   out_power_down, cmos_mode, cmos_in_phase, gpio_drive_out;
  logic [7:0]   gpio_fixed_func, gpio_oe_func, gpio_value, gpio_i, gpio_o;
  logic [7:0]   gpio_oe, gpio_input_state, q, nq, q_oe, coarse_busy;
  logic [15:0]  period;
  logic [7:0]   long_cnt, gap, base;
  int           mismatches, checked, i;

  opc_top i_opc_top (.clk, .resetn, .pll_clk, .ref_clk, .xtal_clk,
    .loss_of_lock_flag, .hold_flag, .los_flag, .switch_event,
    .switch_phase_err, .hitless_switch_select, .phase_slope_rate,
    .output_resync_toggle, .pll1_shutdown, .divider_source_select, .frac_n,
    .frac_f, .frac_int_only, .fine_delay, .int_stage1, .int_stage2,
    .coarse_amount, .coarse_trigger, .out_invert, .out_enable,
    .out_power_down, .cmos_mode, .cmos_in_phase, .config_loaded,
    .gpio_drive_out, .gpio_fixed_func, .gpio_oe_func, .gpio_value, .gpio_i,
    .gpio_o, .gpio_oe, .gpio_input_state, .q, .nq, .q_oe, .coarse_busy,
    .ratio_ok, .pll_settling);

  opc_rx_model #(.NOM(16)) i_opc_rx_model (.clk, .resetn, .line(q[0]),
    .oe(q_oe[0]), .period, .long_cnt, .gap);

  // source clocks off the sampling grid, four clk cycles a period
  assign ref_clk  = {3{pll_clk[0]}};
  assign xtal_clk = pll_clk[1];
  initial begin
    clk     = 1'h0;
    pll_clk = 2'h0;
    fork
      forever #2.5 clk = ~clk;
      begin #1; forever #10 pll_clk = ~pll_clk; end
    join
  end

  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // coarse request: amount then toggle of the trigger bit
  task trig(input int b, input logic [4:0] amt);
    @(negedge clk);
    coarse_amount[b*5 +: 5] = amt;
    coarse_trigger[b]       = ~coarse_trigger[b];
  endtask : trig

  task wait_idle(input int b);
    i = 0;
    while (coarse_busy[b] !== 1'h0 && i < 600) begin
      step(1);
      i++;
    end
    if (i == 600) begin
      mismatches++;
      $display("Error at %0t: busy stuck", $time);
    end
  endtask : wait_idle

  task pulse(input logic [4:0] err);
    @(negedge clk);
    switch_phase_err = {5'h0, err};
    switch_event     = 2'h1;
    step(1);
    switch_event = 2'h0;
  endtask : pulse

  task conclude;
    $display("Counts: %0d mismatches, %0d checked", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // hang guard
  initial begin
    #50000;
    mismatches++;
    conclude();
  end

  initial begin
    {mismatches, checked, resetn, pll1_shutdown, config_loaded} = '0;
    {hold_flag, switch_event, hitless_switch_select} = '0;
    {output_resync_toggle, frac_int_only, los_flag, switch_phase_err} = '0;
    {divider_source_select, frac_f, coarse_trigger, out_power_down} = '0;
    {gpio_drive_out, gpio_fixed_func, gpio_oe_func, gpio_value} = '0;
    loss_of_lock_flag = 2'h3;
    phase_slope_rate  = 4'h0;
    frac_n            = {2{18'h00004}};
    fine_delay        = 8'h48;
    int_stage1        = {8{3'h4}};
    int_stage2        = {8{17'h00001}};
    coarse_amount     = {8{5'h02}};
    out_invert        = 8'h02;
    out_enable        = 8'hFF;
    out_power_down    = 8'h20;
    cmos_mode         = 8'h03;
    cmos_in_phase     = 8'h01;
    gpio_i            = 8'hFF;
    step(3);
    check({q_oe, coarse_busy, gpio_oe, pll_settling}, 26'h3);
    step(3);
    resetn = 1'h1;
    step(4);
    check(q_oe, 8'hDF);
    gpio_i = 8'hF7;
    step(5);
    check(q_oe, 8'hD7);
    config_loaded = 1'h1;
    step(3);
    check(q_oe, 8'hDF);
    out_enable = 8'hBF;
    step(2);
    check(q_oe, 8'h9F);
    // fractional ratio legality table
    frac_n[17:0] = 18'h00003; frac_int_only = 2'h1; step(1);
    check(ratio_ok[0], 1'h1);
    frac_int_only = 2'h0; frac_f[27:0] = 28'h0000001; step(1);
    check(ratio_ok[0], 1'h0);
    frac_n[17:0] = 18'h00004; step(1);
    check(ratio_ok, 2'h3);
    {los_flag, hold_flag, gpio_drive_out, gpio_fixed_func} = 22'h29FFFF;
    step(3);
    check({gpio_o, gpio_oe, gpio_input_state}, 24'hABFFF7);
    gpio_fixed_func = 8'h00; gpio_value = 8'h5A; step(2);
    check(gpio_o, 8'h5A);
    pll1_shutdown = 1'h1;
    loss_of_lock_flag = 2'h2;
    step(60);
    check(pll_settling, 2'h3);
    step(15);
    check(pll_settling, 2'h2);
    step(40);
    for (int k = 0; k < 16; k++) begin
      check({nq[1], q[1], nq[0]}, {~q[1], ~q[0], q[0]});
      step(1);
    end
    check(period, 16'h0010);
    base = long_cnt;
    trig(0, 5'h02);
    step(2);
    check(coarse_busy[0], 1'h1);
    wait_idle(0);
    step(4);
    check({long_cnt - base, gap}, 16'h0204);
    trig(0, 5'h1F); step(2);
    trig(0, 5'h1F); step(2);
    check(coarse_busy[0], 1'h1);
    output_resync_toggle = 2'h1; step(3);
    check(coarse_busy, 8'h00);
    trig(0, 5'h1F); step(2);
    loss_of_lock_flag = 2'h3; step(3);
    check({coarse_busy[0], pll_settling[0]}, 2'h1);
    loss_of_lock_flag = 2'h2; step(80);
    int_stage1[14:12] = 3'h1;
    trig(4, 5'h02); step(3);
    check(coarse_busy[4], 1'h0);
    hitless_switch_select = 2'h1; base = long_cnt;
    pulse(5'h01); step(200);
    check(long_cnt - base, 8'h00);
    hitless_switch_select = 2'h0; base = long_cnt;
    pulse(5'h01); step(200);
    check(long_cnt - base, 8'h01);
    conclude();
  end
endmodule : tb_opc_top
